// ==== brf_defines.vh ====
// Purpose: constants for the channel rate, gain and filter configuration block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   register index times four gives the byte address
`ifndef BRF_DEFINES_VH
`define BRF_DEFINES_VH
`define BRF_IDX_CHAN_CFG     8'h15
`define BRF_IDX_GEN_CFG      8'h10
`define BRF_IDX_RESYNC       8'h09
`define BRF_IDX_STATUS       8'h11
`define BRF_RATE_MSB         23
`define BRF_RATE_LSB         22
`define BRF_GAIN_MSB         17
`define BRF_GAIN_LSB         16
`define BRF_HPF_BIT          14
`define BRF_LPF_MSB          13
`define BRF_LPF_LSB          12
`define BRF_MCLK_MSB         21
`define BRF_MCLK_LSB         20
`define BRF_RATE_RST         2'h2
`define BRF_GAIN_RST         2'h0
`define BRF_HPF_RST          1'h1
`define BRF_LPF_RST          2'h1
`define BRF_MCLK_RST         2'h0
`define BRF_LPF_BYPASS       2'h0
`define BRF_LPF_40HZ         2'h1
`define BRF_LPF_100HZ        2'h2
`define BRF_LPF_150HZ        2'h3
`define BRF_CFG_MASK         24'hc37000
`endif

// ==== brf_config.v ====
// Purpose: channel rate, gain, high-pass and low-pass configuration register with effective-value mapping
// Assumes: classic wishbone slave; one clock; ack one cycle after request
// Notes:   rate figures are in tenths of sps, cutoffs in hundredths of hz
//
// Summary of operation
// - channel config writes pulse a record disturbance flag
// - resync command realigns sample timing
// - rate field bits 23:22, reset code 10
// - master clock 00 gives 512/256/128 sps
// - master clock 01 gives 500/250/125 sps
// - master clock 10 code 10 gives 200 sps
// - master clock 11 code 10 gives 199.8
// - gain field 17:16 selects 20 to 160
// - bit 14 bypasses or applies 0.50hz highpass
// - lowpass code 00 decimates only
// - 100hz/150hz honoured only at allowed rates
// - unsupported lowpass falls back to 40hz internally
// - reads return effective lowpass setting
// - 32768hz cutoffs 40.96, 102.4, 153.6, 28.35
// - 32000hz cutoffs 40.00, 100.0, 150.0, 27.68
// - 200 sps gives 40.00, 199.8 gives 39.96
`timescale 1ns/100ps
`include "brf_defines.vh"
module brf_config (
  input  wire        clk,
  input  wire        nrst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  output reg  [1:0]  output_rate_code,
  output reg  [1:0]  channel_gain_code,
  output reg         highpass_select,
  output reg  [1:0]  lowpass_select,
  output reg  [1:0]  master_clock_select,
  output reg         rate_valid,
  output reg  [12:0] sample_rate_tenths,
  output reg  [7:0]  gain_vv,
  output reg  [15:0] lowpass_cutoff_centihz,
  output reg  [7:0]  highpass_cutoff_centihz,
  output reg         resync_pulse,
  output reg         config_changed
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  reg        ack;
  wire       req = wb_cyc_i & wb_stb_i & ~ack;
  wire [7:0] idx = wb_adr_i[9:2];
  wire       wr  = req & wb_we_i;
  assign wb_ack_o = ack;

  // ---------------------------------------------------------------
  // stored fields
  // ---------------------------------------------------------------
  reg  [1:0] rate_q;
  reg  [1:0] gain_q;
  reg        hpf_q;
  reg  [1:0] lpf_q;
  reg  [1:0] mclk_q;
  reg        resync_seen;
  reg        cfg_dirty;
  reg  [1:0] next_eff_lpf;
  reg        next_rate_valid;
  reg  [12:0] next_rate;
  reg  [15:0] next_cut;

  // effective lowpass and rate decode
  always @* begin
    next_rate_valid = 1'b1;
    next_rate       = 13'h0000;
    next_eff_lpf    = lpf_q;
    next_cut        = 16'h0000;
    case (mclk_q)
      2'h0: begin
        case (rate_q)
          2'h0: next_rate = 13'd5120;
          2'h1: next_rate = 13'd2560;
          2'h2: next_rate = 13'd1280;
          default: next_rate_valid = 1'b0;
        endcase
      end
      2'h1: begin
        case (rate_q)
          2'h0: next_rate = 13'd5000;
          2'h1: next_rate = 13'd2500;
          2'h2: next_rate = 13'd1250;
          default: next_rate_valid = 1'b0;
        endcase
      end
      2'h2: begin
        if (rate_q == 2'h2) begin
          next_rate = 13'd2000;
        end else begin
          next_rate_valid = 1'b0;
        end
      end
      default: begin
        if (rate_q == 2'h2) begin
          next_rate = 13'd1998;
        end else begin
          next_rate_valid = 1'b0;
        end
      end
    endcase
    // 100hz needs a fast rate on the first two clocks, 150hz the fastest
    if (lpf_q == `BRF_LPF_100HZ && !(mclk_q[1] == 1'b0 && rate_q[1] == 1'b0)) begin
      next_eff_lpf = `BRF_LPF_40HZ;
    end
    if (lpf_q == `BRF_LPF_150HZ && !(mclk_q[1] == 1'b0 && rate_q == 2'h0)) begin
      next_eff_lpf = `BRF_LPF_40HZ;
    end
    if (next_eff_lpf == `BRF_LPF_BYPASS) begin
      next_cut = 16'h0000;
    end else begin
      case ({mclk_q, rate_q})
        4'h0: next_cut = (next_eff_lpf == `BRF_LPF_40HZ) ? 16'd4096 :
                         (next_eff_lpf == `BRF_LPF_100HZ) ? 16'd10240 : 16'd15360;
        4'h1: next_cut = (next_eff_lpf == `BRF_LPF_40HZ) ? 16'd4096 : 16'd10240;
        4'h2: next_cut = 16'd2835;
        4'h4: next_cut = (next_eff_lpf == `BRF_LPF_40HZ) ? 16'd4000 :
                         (next_eff_lpf == `BRF_LPF_100HZ) ? 16'd10000 : 16'd15000;
        4'h5: next_cut = (next_eff_lpf == `BRF_LPF_40HZ) ? 16'd4000 : 16'd10000;
        4'h6: next_cut = 16'd2768;
        4'ha: next_cut = 16'd4000;
        4'he: next_cut = 16'd3996;
        default: next_cut = 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register writes and bus answer
  // ---------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack          <= 1'b0;
      rate_q       <= `BRF_RATE_RST;
      gain_q       <= `BRF_GAIN_RST;
      hpf_q        <= `BRF_HPF_RST;
      lpf_q        <= `BRF_LPF_RST;
      mclk_q       <= `BRF_MCLK_RST;
      resync_pulse <= 1'b0;
      resync_seen  <= 1'b0;
      cfg_dirty    <= 1'b0;
      config_changed <= 1'b0;
      wb_dat_o     <= 32'h00000000;
    end else begin
      ack            <= req;
      resync_pulse   <= 1'b0;
      config_changed <= 1'b0;
      if (wr && idx == `BRF_IDX_CHAN_CFG) begin
        config_changed <= 1'b1;
        cfg_dirty      <= 1'b1;
        if (wb_sel_i[2]) begin
          rate_q <= wb_dat_i[`BRF_RATE_MSB:`BRF_RATE_LSB];
          gain_q <= wb_dat_i[`BRF_GAIN_MSB:`BRF_GAIN_LSB];
        end
        if (wb_sel_i[1]) begin
          hpf_q <= wb_dat_i[`BRF_HPF_BIT];
          lpf_q <= wb_dat_i[`BRF_LPF_MSB:`BRF_LPF_LSB];
        end
      end else if (wr && idx == `BRF_IDX_GEN_CFG && wb_sel_i[2]) begin
        mclk_q    <= wb_dat_i[`BRF_MCLK_MSB:`BRF_MCLK_LSB];
        cfg_dirty <= 1'b1;
      end else if (wr && idx == `BRF_IDX_RESYNC) begin
        resync_pulse <= 1'b1;
        resync_seen  <= 1'b1;
        cfg_dirty    <= 1'b0;
      end
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        case (idx)
          `BRF_IDX_CHAN_CFG: wb_dat_o <= {8'h00, rate_q, 4'h0, gain_q, 1'b0, hpf_q, next_eff_lpf, 12'h000};
          `BRF_IDX_GEN_CFG:  wb_dat_o <= {10'h000, mclk_q, 20'h00000};
          `BRF_IDX_STATUS:   wb_dat_o <= {29'h00000000, resync_seen, cfg_dirty, next_rate_valid};
          default:           wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // effective settings to the channel
  // ---------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      output_rate_code        <= `BRF_RATE_RST;
      channel_gain_code       <= `BRF_GAIN_RST;
      highpass_select         <= `BRF_HPF_RST;
      lowpass_select          <= `BRF_LPF_RST;
      master_clock_select     <= `BRF_MCLK_RST;
      rate_valid              <= 1'b1;
      sample_rate_tenths      <= 13'd1280;
      gain_vv                 <= 8'd20;
      lowpass_cutoff_centihz  <= 16'd2835;
      highpass_cutoff_centihz <= 8'd50;
    end else begin
      output_rate_code        <= rate_q;
      channel_gain_code       <= gain_q;
      highpass_select         <= hpf_q;
      lowpass_select          <= next_eff_lpf;
      master_clock_select     <= mclk_q;
      rate_valid              <= next_rate_valid;
      sample_rate_tenths      <= next_rate;
      gain_vv                 <= 8'd20 << gain_q;
      lowpass_cutoff_centihz  <= next_cut;
      highpass_cutoff_centihz <= hpf_q ? 8'd50 : 8'd0;
    end
  end
endmodule

// ==== brf_config_assertions.sv ====
// Purpose: port-level checker for the channel rate, gain and filter configuration block
// Assumes: ack one cycle after a taken request, outputs settle together
// Notes:   attached by the bind after the module
`timescale 1ns/100ps
module brf_chk (
  input wire logic        clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic        highpass_select, rate_valid, resync_pulse, config_changed,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [1:0]  output_rate_code, channel_gain_code, lowpass_select, master_clock_select,
  input wire logic [12:0] sample_rate_tenths,
  input wire logic [7:0]  gain_vv, highpass_cutoff_centihz,
  input wire logic [15:0] lowpass_cutoff_centihz
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  AST_ACK: assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
  AST_NOACK: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("ack without request");
  AST_CHG: assert property (config_changed == $past(req && wb_we_i && wb_adr_i[9:2] == 8'h15))
    else $error("change pulse does not follow config write");
  AST_SYNC: assert property (resync_pulse == $past(req && wb_we_i && wb_adr_i[9:2] == 8'h09))
    else $error("resync pulse does not follow command");
  AST_GAIN: assert property (gain_vv == (8'h14 << channel_gain_code)) else $error("gain value wrong");
  AST_HPF: assert property (highpass_cutoff_centihz == (highpass_select ? 8'h32 : 8'h00))
    else $error("highpass cutoff wrong");
  AST_BYP: assert property (lowpass_select == 2'h0 |-> lowpass_cutoff_centihz == 16'h0)
    else $error("bypass shows a cutoff");
  AST_LP: assert property (rate_valid && lowpass_select[1] |-> !master_clock_select[1] &&
    output_rate_code != 2'h2 && (lowpass_select == 2'h2 || output_rate_code == 2'h0))
    else $error("unsupported lowpass in use");
  AST_R4: assert property (rate_valid && master_clock_select == 2'h0 |->
    sample_rate_tenths == (13'h0500 << (2'h2 - output_rate_code))) else $error("rate wrong");
  AST_R67: assert property (master_clock_select[1] |-> rate_valid == (output_rate_code == 2'h2))
    else $error("rate validity wrong");
  cover property (config_changed);
  cover property (resync_pulse);
  cover property (rate_valid && lowpass_select == 2'h3);
  cover property (rate_valid && master_clock_select == 2'h3);
endmodule
bind brf_config brf_chk u_chk (.*);

// ==== test_brf_config.sv ====
// Purpose: self-checking bench for the channel rate, gain and filter configuration block
// Assumes: classic wishbone, one request at a time
// Notes:   expected reads queued, checked when ack appears
`timescale 1ns/100ps
module test_brf_config;
  logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [9:0]  adr = 10'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, x = 32'd88836;
  logic [12:0] srt, e_rt = 13'd1280;
  logic [15:0] cut, e_ct = 16'd2835;
  logic [60:0] q[$];
  int          fails = 0, samples_checked = 0;
  always #2 clk = ~clk;
  brf_config u_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .output_rate_code(), .channel_gain_code(),
    .highpass_select(), .lowpass_select(), .master_clock_select(), .rate_valid(), .sample_rate_tenths(srt),
    .gain_vv(), .lowpass_cutoff_centihz(cut), .highpass_cutoff_centihz(), .resync_pulse(), .config_changed());
  function automatic logic [31:0] rnd();
    x ^= x << 13; x ^= x >> 17; x ^= x << 5;
    return x;
  endfunction
  function automatic logic [1:0] ef(int m, int r, int l);
    if (l == 3 && !(m < 2 && r == 0)) return 2'h1;
    if (l == 2 && !(m < 2 && r < 2)) return 2'h1;
    return 2'(l);
  endfunction
  function automatic logic [15:0] ct(int m, int r, int e);
    int b[4] = '{4096, 4000, 4000, 3996};
    if (e == 0) return 16'h0;
    if (r == 2 && m < 2) return 16'(m ? 2768 : 2835);
    return 16'(e == 1 ? b[m] : m ? (e == 2 ? 10000 : 15000) : (e == 2 ? 10240 : 15360));
  endfunction
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    if (!w) q.push_back({e, e_rt, e_ct});
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 40);
    cyc <= 0; stb <= 0;
    if (n >= 40) begin fails++; print_verdict(); end
  endtask
  always @(posedge clk) if (ack === 1'b1 && we === 1'b0) begin
    if (q.size() == 0) cmp(32'h1, 32'h0);
    else begin
      cmp(rd, q[0][60:29]);
      cmp({19'h0, srt}, {19'h0, q[0][28:16]});
      cmp({16'h0, cut}, {16'h0, q[0][15:0]});
      void'(q.pop_front());
    end
  end
  initial begin
    int m, r, l;
    logic [31:0] v;
    logic [1:0] e;
    repeat (10) @(posedge clk);
    nrst <= 1;
    bus(0, 10'h054, 0, 32'h00805000);
    $display("reset values checked");
    for (m = 0; m < 4; m++) begin
      bus(1, 10'h040, 32'(m) << 20, 0);
      for (r = (m < 2) ? 0 : 2; r < 3; r++)
        for (l = 0; l < 4; l++) begin
          v = rnd() & 32'h00034000 | 32'(r) << 22 | 32'(l) << 12;
          e = ef(m, r, l);
          bus(1, 10'h054, v, 0);
          e_rt = 13'(m < 2 ? (m ? 5000 : 5120) >> r : (m == 2 ? 2000 : 1998));
          e_ct = ct(m, r, e);
          bus(0, 10'h054, 0, v & 32'h00c34000 | 32'(e) << 12);
        end
    end
    $display("rate and filter table checked");
    bus(1, 10'h054, 32'h00801000, 0);
    bus(0, 10'h044, 0, 32'h3);
    bus(1, 10'h024, 0, 0);
    bus(0, 10'h044, 0, 32'h5);
    bus(1, 10'h3fc, 32'hffffffff, 0);
    bus(0, 10'h3fc, 0, 32'h0);
    bus(0, 10'h054, 0, 32'h00801000);
    $display("resync and unmapped access checked");
    print_verdict();
  end
endmodule
